// ==== hdl/ubd_baud_gen.sv ====
`timescale 1ns/1ps
module ubd_baud_gen
  import ubd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        refTick,
  input  wire logic [15:0] divisor,
  output logic             tick16,
  output logic             bitTick
);

  typedef struct packed {
    logic [3:0]  pre;
    logic [15:0] cnt;
    logic        tick16;
    logic        bitTick;
  } ubd_bg_state_t;

  ubd_bg_state_t s;
  ubd_bg_state_t next_s;

  // ---------------------------------------------------------------
  // Prescale and divide
  // ---------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.tick16  = 1'b0;
    next_s.bitTick = 1'b0;
    if (refTick) begin
      next_s.pre = s.pre + 4'h1;
      if (s.pre == PRE_LAST) begin
        next_s.tick16 = 1'b1;
        // Zero divisor parks the bit counter
        if (divisor == 16'h0000) begin
          next_s.cnt = 16'h0000;
        end else if (s.cnt >= divisor - 16'h0001) begin
          next_s.cnt     = 16'h0000;
          next_s.bitTick = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick16  = s.tick16;
  assign bitTick = s.bitTick;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_div16;
    @(posedge clock) disable iff (!rst_n)
      refTick && s.pre == PRE_LAST |=> tick16;
  endproperty
  a_div16: assert property (p_div16) else $error("16x tick missing");

  property p_div_end;
    @(posedge clock) disable iff (!rst_n)
      refTick && s.pre == PRE_LAST && divisor != 16'h0000
        && s.cnt == divisor - 16'h0001 |=> bitTick && s.cnt == 16'h0000;
  endproperty
  a_div_end: assert property (p_div_end) else $error("bit tick missing");

  property p_parked;
    @(posedge clock) disable iff (!rst_n)
      divisor == 16'h0000 && $past(divisor) == 16'h0000 |-> !bitTick;
  endproperty
  a_parked: assert property (p_parked) else $error("tick with zero");

  property p_rate_one;
    @(posedge clock) disable iff (!rst_n)
      tick16 && divisor == 16'h0001 && $past(divisor) == 16'h0001
        |-> bitTick;
  endproperty
  a_rate_one: assert property (p_rate_one) else $error("divide by one");

endmodule : ubd_baud_gen

// ==== hdl/ubd_dma_irq.sv ====
`timescale 1ns/1ps
module ubd_dma_irq
  import ubd_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire ubd_chan_in_t chanIn,
  input  wire logic [7:0]   fifoControl,
  output logic              irq,
  output logic [7:0]        lineStatus
);

  typedef struct packed {
    logic       irq;
    logic [7:0] line_status_reg;
  } ubd_di_state_t;

  ubd_di_state_t s;
  ubd_di_state_t next_s;
  logic [4:0]    trig;
  logic          blockMode;

  assign blockMode = fifoControl[FCR_DMA_MODE] & fifoControl[FCR_FIFO_EN];

  always_comb begin
    case (fifoControl[FCR_TRIG_LO +: 2])
      2'h0:    trig = TRIG_LVL0;
      2'h1:    trig = TRIG_LVL1;
      2'h2:    trig = TRIG_LVL2;
      default: trig = TRIG_LVL3;
    endcase
  end

  always_comb begin
    next_s = s;
    if (blockMode) begin
      next_s.irq = (chanIn.txLevel < FIFO_DEPTH)
                 | (chanIn.rxLevel > trig);
    end else begin
      next_s.irq = chanIn.txDone | chanIn.rxDone;
    end
    next_s.line_status_reg = 8'h00;
    next_s.line_status_reg[LSR_TX_EMPTY] = chanIn.txShiftEmpty
                             & (chanIn.txLevel == 5'h00);
    next_s.line_status_reg[LSR_TX_FREE]  = chanIn.txLevel < FIFO_DEPTH;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.line_status_reg <= RST_LSR;
    end else begin
      s <= next_s;
    end
  end

  assign irq        = s.irq;
  assign lineStatus = s.line_status_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_char_evt;
    !blockMode && (chanIn.txDone || chanIn.rxDone);
  endsequence

  sequence s_idle_char;
    !blockMode && !chanIn.txDone && !chanIn.rxDone;
  endsequence

  property p_mode0;
    @(posedge clock) disable iff (!rst_n) s_char_evt |=> irq;
  endproperty
  a_mode0: assert property (p_mode0) else $error("no char irq");

  property p_quiet;
    @(posedge clock) disable iff (!rst_n) s_idle_char |=> !irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious irq");

  property p_tx_room;
    @(posedge clock) disable iff (!rst_n)
      blockMode && chanIn.txLevel < FIFO_DEPTH |=> irq;
  endproperty
  a_tx_room: assert property (p_tx_room) else $error("tx room irq");

  property p_rx_block;
    @(posedge clock) disable iff (!rst_n)
      blockMode && chanIn.txLevel == FIFO_DEPTH && chanIn.rxLevel <= trig
        |=> !irq;
  endproperty
  a_rx_block: assert property (p_rx_block) else $error("rx irq early");

  property p_free;
    @(posedge clock) disable iff (!rst_n)
      chanIn.txLevel == FIFO_DEPTH |=> !lineStatus[LSR_TX_FREE];
  endproperty
  a_free: assert property (p_free) else $error("tx free wrong");

endmodule : ubd_dma_irq

// ==== hdl/ubd_pkg.sv ====
// Operation
// - Each channel owns an independent baud generator
// - Reference clock first divided by sixteen
// - 16x clock divided by 16-bit divisor
// - Divisor formed from high and low bytes
// - 1.8432 MHz: 0x0C 9600, 0x01 115200
// - Reference from internal oscillator or input pin
// - Status bits six/five: empty, free slot
// - FIFO control bit three selects DMA mode, only with FIFO enable bit zero also set
// - Mode 0: interrupt per character moved
// - Mode 1: tx below 16 or rx above trigger
// - Divisor reachable only with divisor-access bit set
// - FIFO enable bit zero; trigger bits seven/six
package ubd_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int         NCH        = 2;
  localparam logic [3:0] PRE_LAST   = 4'hF;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_LVL0  = 5'h01;
  localparam logic [4:0] TRIG_LVL1  = 5'h04;
  localparam logic [4:0] TRIG_LVL2  = 5'h08;
  localparam logic [4:0] TRIG_LVL3  = 5'h0E;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_LCR      = 8'h00;
  localparam logic [7:0] OFF_DIV_LO   = 8'h04;
  localparam logic [7:0] OFF_DIV_HI   = 8'h08;
  localparam logic [7:0] OFF_FCR      = 8'h0C;
  localparam logic [7:0] OFF_LSR      = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST   = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_CLK_SEL  = 8'h48;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         LCR_DIV_ACCESS = 7;
  localparam int         FCR_FIFO_EN    = 0;
  localparam int         FCR_DMA_MODE   = 3;
  localparam int         FCR_TRIG_LO    = 6;
  localparam int         LSR_TX_EMPTY   = 6;
  localparam int         LSR_TX_FREE    = 5;
  localparam logic [7:0] RST_LCR        = 8'h00;
  localparam logic [7:0] RST_DIV        = 8'h00;
  localparam logic [7:0] RST_FCR        = 8'h00;
  localparam logic [7:0] RST_LSR        = 8'h60;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] txLevel;
    logic [4:0] rxLevel;
    logic       txShiftEmpty;
    logic       txDone;
    logic       rxDone;
  } ubd_chan_in_t;

  typedef struct packed {
    logic [7:0] lineControl;
    logic [7:0] divLow;
    logic [7:0] divisor_high_byte;
    logic [7:0] fifoControl;
  } ubd_chan_cfg_t;

endpackage : ubd_pkg

// ==== hdl/ubd_top.sv ====
`timescale 1ns/1ps
module ubd_top
  import ubd_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Reference oscillator
  input  wire logic                     osc_input_pin,
  output logic                          osc_output_pin,
  // Per channel user side
  input  wire ubd_chan_in_t [NCH-1:0]   chanIn,
  output logic [NCH-1:0]                tick16,
  output logic [NCH-1:0]                bitTick,
  output logic [NCH-1:0]                chanIrq,
  output logic [NCH-1:0][7:0]           fifoControl,
  output logic                          irq
);

  typedef struct packed {
    logic [1:0]                oscSync;
    logic                      oscPrev;
    logic                      oscOut;
    logic                      awHeld;
    logic                      wHeld;
    logic [7:0]                awAddr;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    ubd_chan_cfg_t [NCH-1:0]   cfg;
    logic                      clkSel;
    logic [NCH-1:0]            irqSt;
    logic [NCH-1:0]            irqMask;
    logic [NCH-1:0]            irqPrev;
  } ubd_top_state_t;

  ubd_top_state_t        s;
  ubd_top_state_t        next_s;
  logic [NCH-1:0][7:0]   lineStatus;
  logic                  refTick;
  logic                  doWrite;
  logic                  wrInChan;
  logic                  wrCh;
  logic [7:0]            wrOff;
  logic                  rdInChan;
  logic                  rdCh;
  logic [7:0]            rdOff;

  // ---------------------------------------------------------------
  // Reference clock selection
  // ---------------------------------------------------------------
  // External reference is sampled; 80 MHz stays under half of clock
  assign refTick = s.clkSel ? (s.oscSync[1] & ~s.oscPrev) : 1'b1;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    ubd_baud_gen u_gen (
      .clock   (clock),
      .rst_n   (rst_n),
      .refTick (refTick),
      .divisor ({s.cfg[c].divisor_high_byte, s.cfg[c].divLow}),
      .tick16  (tick16[c]),
      .bitTick (bitTick[c])
    );
    ubd_dma_irq u_dma (
      .clock       (clock),
      .rst_n       (rst_n),
      .chanIn      (chanIn[c]),
      .fifoControl (s.cfg[c].fifoControl),
      .irq         (chanIrq[c]),
      .lineStatus  (lineStatus[c])
    );
    assign fifoControl[c] = s.cfg[c].fifoControl;
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign doWrite  = s.awHeld & s.wHeld & ~s.bvalid;
  assign wrInChan = s.awAddr[7:6] == 2'h0;
  assign wrCh     = s.awAddr[5];
  assign wrOff    = {3'h0, s.awAddr[4:0]};
  assign rdInChan = s_axi_araddr[7:6] == 2'h0;
  assign rdCh     = s_axi_araddr[5];
  assign rdOff    = {3'h0, s_axi_araddr[4:0]};

  assign s_axi_awready = ~s.awHeld & ~s.bvalid;
  assign s_axi_wready  = ~s.wHeld & ~s.bvalid;
  assign s_axi_arready = ~s.rvalid;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic          dlab;
    logic          rdDlab;
    logic [1:0]    resp;
    logic [7:0]    rbyte;
    logic [NCH-1:0] clr;
    dlab   = s.cfg[wrCh].lineControl[LCR_DIV_ACCESS];
    rdDlab = s.cfg[rdCh].lineControl[LCR_DIV_ACCESS];
    resp   = RESP_OKAY;
    rbyte  = 8'h00;
    clr    = '0;
    next_s = s;

    next_s.oscSync = {s.oscSync[0], osc_input_pin};
    next_s.oscPrev = s.oscSync[1];
    // Crystal amplifier stand-in: inverted reference
    next_s.oscOut  = ~s.oscSync[1];

    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end

    // Write: both halves held, answer after
    if (doWrite) begin
      if (wrInChan) begin
        case (wrOff)
          OFF_LCR: begin
            if (s.wStrb[0]) begin
              next_s.cfg[wrCh].lineControl = s.wData[7:0];
            end
          end
          OFF_DIV_LO: begin
            if (s.wStrb[0] && dlab) begin
              next_s.cfg[wrCh].divLow = s.wData[7:0];
            end
          end
          OFF_DIV_HI: begin
            if (s.wStrb[0] && dlab) begin
              next_s.cfg[wrCh].divisor_high_byte = s.wData[7:0];
            end
          end
          OFF_FCR: begin
            // Reset bits are strobes of the FIFO logic, not kept
            if (s.wStrb[0]) begin
              next_s.cfg[wrCh].fifoControl = s.wData[7:0] & 8'hC9;
            end
          end
          OFF_LSR: resp = RESP_OKAY;
          default: resp = RESP_SLVERR;
        endcase
      end else begin
        case (s.awAddr)
          OFF_IRQ_ST: begin
            if (s.wStrb[0]) begin
              clr = s.wData[NCH-1:0];
            end
          end
          OFF_IRQ_MASK: begin
            if (s.wStrb[0]) begin
              next_s.irqMask = s.wData[NCH-1:0];
            end
          end
          OFF_CLK_SEL: begin
            if (s.wStrb[0]) begin
              next_s.clkSel = s.wData[0];
            end
          end
          default: resp = RESP_SLVERR;
        endcase
      end
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = resp;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read: answer one cycle after address taken
    if (s_axi_arvalid && s_axi_arready) begin
      resp = RESP_OKAY;
      if (rdInChan) begin
        case (rdOff)
          OFF_LCR:    rbyte = s.cfg[rdCh].lineControl;
          OFF_DIV_LO: rbyte = rdDlab ? s.cfg[rdCh].divLow : 8'h00;
          OFF_DIV_HI: begin
            rbyte = rdDlab ? s.cfg[rdCh].divisor_high_byte : 8'h00;
          end
          OFF_FCR:    rbyte = s.cfg[rdCh].fifoControl;
          OFF_LSR:    rbyte = lineStatus[rdCh];
          default:    resp  = RESP_SLVERR;
        endcase
      end else begin
        case (s_axi_araddr)
          OFF_IRQ_ST:   rbyte = {{(8-NCH){1'b0}}, s.irqSt};
          OFF_IRQ_MASK: rbyte = {{(8-NCH){1'b0}}, s.irqMask};
          OFF_CLK_SEL:  rbyte = {7'h00, s.clkSel};
          default:      resp  = RESP_SLVERR;
        endcase
      end
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h000000, rbyte};
      next_s.rresp  = resp;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Sticky events; a new rising edge beats the clear
    next_s.irqPrev = chanIrq;
    next_s.irqSt   = (s.irqSt & ~clr) | (chanIrq & ~s.irqPrev);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      for (int c = 0; c < NCH; c++) begin
        s.cfg[c].lineControl       <= RST_LCR;
        s.cfg[c].divLow            <= RST_DIV;
        s.cfg[c].divisor_high_byte <= RST_DIV;
        s.cfg[c].fifoControl       <= RST_FCR;
      end
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign osc_output_pin = s.oscOut;
  assign irq            = |(s.irqSt & s.irqMask);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_div_locked;
    @(posedge clock) disable iff (!rst_n)
      doWrite && wrInChan && wrOff == OFF_DIV_LO
        && !s.cfg[wrCh].lineControl[LCR_DIV_ACCESS]
        |=> $stable(s.cfg[wrCh].divLow);
  endproperty
  a_div_locked: assert property (p_div_locked) else $error("locked write");

  property p_div_open;
    @(posedge clock) disable iff (!rst_n)
      doWrite && wrInChan && wrOff == OFF_DIV_HI && s.wStrb[0]
        && s.cfg[wrCh].lineControl[LCR_DIV_ACCESS]
        |=> s.cfg[$past(wrCh)].divisor_high_byte == $past(s.wData[7:0]);
  endproperty
  a_div_open: assert property (p_div_open) else $error("high byte lost");

endmodule : ubd_top

// ==== tb/uart_baud_gen_and_dma_mode_tb_top.sv ====
`timescale 1ns/1ps
module uart_baud_gen_and_dma_mode_tb_top
  import ubd_pkg::*;
;
  typedef struct {int c; logic [15:0] div;} ubd_row_t;
  logic                   clock;
  logic                   rst_n;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  logic                   awvalid, awready, wvalid, wready, bvalid;
  logic                   bready, arvalid, arready, rvalid, rready;
  logic                   oscRun;
  logic                   oscOut;
  logic [1:0]             oscCnt = 2'h0;
  ubd_chan_in_t [NCH-1:0] chanIn;
  logic [NCH-1:0]         tick16, bitTick, chanIrq;
  logic [NCH-1:0][7:0]    fifoControl;
  logic                   irq;
  int                     errors, check_count, p, irqHigh;
  logic [4:0]             lv [4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2,
                                     TRIG_LVL3};
  // Divisors only grow per channel; on a shrink the >= compare resets the counter at the next 16x tick
  ubd_row_t rows [4] = '{'{0, 16'h0001}, '{1, 16'h0003},
                         '{0, 16'h0180}, '{1, 16'h000C}};

  ubd_top dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_input_pin(oscCnt[1]), .osc_output_pin(oscOut),
    .chanIn(chanIn), .tick16(tick16), .bitTick(bitTick),
    .chanIrq(chanIrq), .fifoControl(fifoControl), .irq(irq)
  );
  ubd_host_model host (
    .clock(clock), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (oscRun) oscCnt <= oscCnt + 2'h1;
  end
  always @(negedge clock) begin
    if (chanIrq[0] === 1'h1) irqHigh++;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic giveUp();
    errors++;
    end_of_test();
  endtask : giveUp
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    bit         ok;
    host.write(a, d, r, ok);
    if (!ok) giveUp();
    check("bresp", 32'(r), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    host.read(a, d, r, ok);
    if (!ok) giveUp();
    check("rdata", d, e);
    check("rresp", 32'(r), 32'(er));
  endtask : rd
  task automatic setDiv(input int c, input logic [15:0] v);
    logic [7:0] b;
    b = 8'(c * 32);
    wr(b + OFF_LCR, 32'h80);
    wr(b + OFF_DIV_LO, 32'(v[7:0]));
    wr(b + OFF_DIV_HI, 32'(v[15:8]));
    wr(b + OFF_LCR, 32'h0);
  endtask : setDiv
  task automatic period(input bit t16, input int c, output int n);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
        if (n > 20000) giveUp();
      end while ((t16 ? tick16[c] : bitTick[c]) !== 1'h1);
    end
    @(posedge clock);
  endtask : period
  task automatic lvl(input logic [4:0] tx, rx, input logic e);
    chanIn[0].txLevel <= tx;
    chanIn[0].rxLevel <= rx;
    repeat (3) @(negedge clock);
    check("chanIrq", 32'(chanIrq[0]), 32'(e));
    @(posedge clock);
  endtask : lvl
  task automatic line_status_reg(input logic [4:0] tx, input logic se,
                     input logic [7:0] e);
    chanIn[1].txLevel      <= tx;
    chanIn[1].txShiftEmpty <= se;
    repeat (3) @(posedge clock);
    rd(8'h30, 32'(e));
  endtask : line_status_reg

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    {rst_n, oscRun, errors, check_count} = '0;
    chanIn = '0;
    chanIn[0].txShiftEmpty = 1'h1;
    chanIn[1].txShiftEmpty = 1'h1;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    rd(OFF_LSR, 32'(RST_LSR));
    rd(OFF_FCR, 32'(RST_FCR));
    check("fifoControl", 32'(fifoControl), 32'h0);
    period(1'h1, 0, p);
    check("tick16", p, 16);
    foreach (rows[i]) begin
      setDiv(rows[i].c, rows[i].div);
      period(1'h0, rows[i].c, p);
      check("bitPeriod", p, 16 * rows[i].div);
    end
    period(1'h0, 0, p);
    check("bitPeriod", p, 16 * 32'h180);
    wr(OFF_CLK_SEL, 32'h1);
    oscRun <= 1'h1;
    period(1'h1, 0, p);
    check("tick16Ext", p, 64);
    oscRun <= 1'h0;
    wr(OFF_CLK_SEL, 32'h0);
    check("oscOut", 32'(oscOut), {31'h0, ~oscCnt[1]});
    wr(8'h24, 32'h0D);
    rd(8'h24, 32'h0);
    wr(8'h20, 32'h80);
    rd(8'h24, 32'h0C);
    wr(8'h24, 32'h0D);
    rd(8'h24, 32'h0D);
    wr(8'h20, 32'h0);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    line_status_reg(5'h00, 1'h1, 8'h60);
    line_status_reg(5'h10, 1'h1, 8'h00);
    line_status_reg(5'h03, 1'h1, 8'h20);
    line_status_reg(5'h00, 1'h0, 8'h20);
    foreach (lv[t]) begin
      wr(OFF_FCR, {24'h0, 2'(t), 6'h09});
      lvl(5'h10, lv[t], 1'h0);
      lvl(5'h10, lv[t] + 5'h1, 1'h1);
      lvl(5'h0F, lv[t], 1'h1);
      check("fcr", 32'(fifoControl[0]), {24'h0, 2'(t), 6'h09});
    end
    wr(OFF_FCR, 32'h01);
    lvl(5'h00, 5'h10, 1'h0);
    p = irqHigh;
    chanIn[0].rxDone <= 1'h1;
    @(posedge clock);
    chanIn[0].rxDone <= 1'h0;
    chanIn[0].txDone <= 1'h1;
    @(posedge clock);
    chanIn[0].txDone <= 1'h0;
    repeat (6) @(posedge clock);
    check("irqCount", irqHigh - p, 2);
    wr(OFF_FCR, 32'h08);
    lvl(5'h00, 5'h10, 1'h0);
    wr(OFF_FCR, 32'h09);
    wr(OFF_IRQ_MASK, 32'h0);
    lvl(5'h10, 5'h00, 1'h0);
    wr(OFF_IRQ_ST, 32'h3);
    rd(OFF_IRQ_ST, 32'h0);
    lvl(5'h0F, 5'h00, 1'h1);
    rd(OFF_IRQ_ST, 32'h1);
    check("irqMasked", 32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    @(negedge clock);
    check("irq", 32'(irq), 32'h1);
    @(posedge clock);
    wr(OFF_IRQ_ST, 32'h1);
    rd(OFF_IRQ_ST, 32'h0);
    @(negedge clock);
    check("irqClr", 32'(irq), 32'h0);
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (8) @(posedge clock);
    check("fifoControl", 32'(fifoControl), 32'h0);
    rst_n <= 1'h1;
    @(posedge clock);
    rd(OFF_FCR, 32'h0);
    end_of_test();
  end
endmodule : uart_baud_gen_and_dma_mode_tb_top

// ==== tb/ubd_host_model.sv ====
`timescale 1ns/1ps
module ubd_host_model (
  input  wire logic        clock,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // --------------------
  // Bus cycles
  // --------------------
  // Handshakes sampled 1 ns after an edge: ready is settled there
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] resp, output bit ok);
    bit tA;
    bit tW;
    int n;
    n = 0;
    ok = 0;
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!ok && n < 64) begin
      #1;
      tA = awvalid && awready;
      tW = wvalid && wready;
      ok = bvalid && bready;
      resp = bresp;
      @(posedge clock);
      n++;
      if (tA) awvalid <= 1'h0;
      if (tW) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    awaddr <= ~a;
    wdata  <= ~d;
    // One idle edge so a following call never reassigns in this step
    @(posedge clock);
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp, output bit ok);
    bit tA;
    int n;
    n = 0;
    ok = 0;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!ok && n < 64) begin
      #1;
      tA = arvalid && arready;
      ok = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clock);
      n++;
      if (tA) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    araddr <= ~a;
    @(posedge clock);
  endtask : read
endmodule : ubd_host_model
